// File: wshp_pkg.sv
package wshp_pkg;
  // Word geometry
  localparam int WORD_W = 32;
  localparam int HALF_W = 16;
  localparam int BCNT_W = 5;
  localparam logic [4:0] LAST_BIT_32 = 5'h1F;
  localparam logic [4:0] LAST_BIT_16 = 5'h0F;
  localparam logic [4:0] BCNT_ZERO = 5'h00;
  localparam logic [4:0] BCNT_ONE = 5'h01;

  // Command word layout
  localparam int CMD_WR_32 = 31;
  localparam int CMD_WR_16 = 15;
  localparam int ADDR_W = 4;

  // Register addresses carried in the command word
  localparam logic [3:0] REG_CFG = 4'h0;
  localparam logic [3:0] REG_MADDR = 4'h1;
  localparam logic [3:0] REG_MDATA = 4'h2;
  localparam logic [3:0] REG_CTRL = 4'h3;

  // Configuration register fields
  localparam int CFG_W = 5;
  localparam int CFG_ORD_LSB = 0;
  localparam int CFG_HALF = 2;
  localparam int CFG_SHRISE = 3;
  localparam int CFG_FC = 4;
  localparam logic [4:0] CFG_RST = 5'h11;

  // Control/status register fields
  localparam int CTRL_WAKE = 0;
  localparam int CTRL_ATTN = 1;
  localparam int CTRL_RUN = 2;

  // Internal memory
  localparam int MEM_DEPTH = 16;
  localparam int MEM_AW = 4;
  localparam logic [3:0] MADDR_ONE = 4'h1;

  // Synchroniser reset image: sck, mosi, sel_n, strap, power, slow clock
  localparam int SYNC_W = 6;
  localparam logic [5:0] SYNC_RST = 6'h2A;

  // Start-up counts
  localparam logic [1:0] SLOW_EDGES = 2'h2;
  localparam logic [1:0] CAP_DLY = 2'h2;
  localparam logic [1:0] CNT2_ONE = 2'h1;

  // Byte orders
  typedef enum logic [1:0] {
    ORD_MIX = 2'b00,
    ORD_MSB = 2'b01,
    ORD_LSB = 2'b10
  } wshp_ord_t;
  localparam logic [1:0] ORD16_SWAP = 2'b01;

  // Frame phases
  typedef enum logic [1:0] {
    ST_CMD = 2'b00,
    ST_WR = 2'b01,
    ST_RD = 2'b10
  } wshp_state_t;

  // 32-bit wire order; every mapping is its own inverse
  function automatic logic [31:0] order32(input logic [31:0] w, input logic [1:0] ord);
    logic [31:0] r;
    r = w;
    if (ord == ORD_MIX) begin
      r = {w[15:8], w[7:0], w[31:24], w[23:16]};
    end else if (ord == ORD_LSB) begin
      r = {w[7:0], w[15:8], w[23:16], w[31:24]};
    end
    return r;
  endfunction : order32

  // 16-bit wire order; swap is its own inverse
  function automatic logic [15:0] order16(input logic [15:0] w, input logic [1:0] ord);
    return (ord == ORD16_SWAP) ? {w[7:0], w[15:8]} : w;
  endfunction : order16
endpackage : wshp_pkg

// File: wshp_sync.sv
`timescale 1ns/10ps
module wshp_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  // Two stages; the first is read only by the second
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      meta_q <= RST_VAL;
      sync_q <= RST_VAL;
    end else if (ce_i) begin
      meta_q <= d_i;
      sync_q <= meta_q;
    end
  end

  assign q_o = sync_q;
endmodule : wshp_sync

// File: wshp_top.sv
`timescale 1ns/10ps
module wshp_top (
  input wire logic SYS_CLK_I,
  input wire logic RST_N_I,
  input wire logic CE_I,
  input wire logic SPI_CLK_I,
  input wire logic SPI_MOSI_I,
  input wire logic DEVICE_SELECT_N_I,
  input wire logic INTERFACE_SELECT_STRAP_I,
  input wire logic POWER_ENABLE_IN_I,
  input wire logic SLOW_CLOCK_IN_I,
  input wire logic ATTN_SET_I,
  output logic DEVICE_TO_HOST_LINE_O,
  output logic DEVICE_TO_HOST_LINE_OE_N_O,
  output logic ATTENTION_REQUEST_OUT_O,
  output logic WAKE_O,
  output logic SPI_SELECTED_O,
  output logic RUNNING_O
);
  logic [wshp_pkg::SYNC_W-1:0] sync_s;
  logic sck_s, mosi_s, sel_n_s, strap_s, pwr_s, slow_s;
  logic sck_prev_q, sel_n_prev_q, slow_prev_q;
  logic [1:0] slow_cnt_q;
  logic [1:0] cap_cnt_q;
  logic cap_done_q, strap_q;
  logic [wshp_pkg::BCNT_W-1:0] bit_cnt_q;
  logic [wshp_pkg::WORD_W-1:0] rx_sr_q, tx_sr_q;
  logic out_q;
  wshp_pkg::wshp_state_t st_q;
  logic [wshp_pkg::ADDR_W-1:0] addr_q;
  logic [wshp_pkg::CFG_W-1:0] cfg_q, cfg_pend_q;
  logic [wshp_pkg::MEM_AW-1:0] maddr_q;
  logic [wshp_pkg::WORD_W-1:0] mem_q [wshp_pkg::MEM_DEPTH];
  logic wake_q, attn_q;

  // Pin synchronisers
  wshp_sync #(
    .W(wshp_pkg::SYNC_W),
    .RST_VAL(wshp_pkg::SYNC_RST)
  ) u_sync (
    .clk_i(SYS_CLK_I),
    .rst_n_i(RST_N_I),
    .ce_i(CE_I),
    .d_i({SPI_CLK_I, SPI_MOSI_I, DEVICE_SELECT_N_I, INTERFACE_SELECT_STRAP_I,
          POWER_ENABLE_IN_I, SLOW_CLOCK_IN_I}),
    .q_o(sync_s)
  );
  assign {sck_s, mosi_s, sel_n_s, strap_s, pwr_s, slow_s} = sync_s;

  // Port qualification
  wire slow_ok = (slow_cnt_q == wshp_pkg::SLOW_EDGES);
  wire spi_mode = cap_done_q & ~strap_q;
  wire run = pwr_s & slow_ok;
  wire sel_act = ~sel_n_s & run & spi_mode;
  wire frame_end = sel_n_s & ~sel_n_prev_q;

  // Edge detection on the sampled link clock
  // mode 3 edges
  wire rise = sel_act & sck_s & ~sck_prev_q;
  wire fall = sel_act & ~sck_s & sck_prev_q;
  wire half = cfg_q[wshp_pkg::CFG_HALF];
  wire [1:0] ord = cfg_q[wshp_pkg::CFG_ORD_LSB +: 2];
  wire sh_rise = cfg_q[wshp_pkg::CFG_SHRISE];
  wire launch = sh_rise ? rise : fall;
  wire [4:0] last_bit = half ? wshp_pkg::LAST_BIT_16 : wshp_pkg::LAST_BIT_32;
  wire word_done = rise & (bit_cnt_q == last_bit);
  wire [31:0] rx_full = {rx_sr_q[30:0], mosi_s};

  // Received word back in register order
  wire [15:0] rx_w16 = wshp_pkg::order16(rx_full[15:0], ord);
  wire [31:0] rx_word = half ? {16'h0000, rx_w16} : wshp_pkg::order32(rx_full, ord);

  // Command decode
  wire cmd_wr = half ? rx_word[wshp_pkg::CMD_WR_16] : rx_word[wshp_pkg::CMD_WR_32];
  wire [3:0] cmd_addr = rx_word[wshp_pkg::ADDR_W-1:0];
  wire in_cmd = (st_q == wshp_pkg::ST_CMD);
  wire [3:0] acc_addr = in_cmd ? cmd_addr : addr_q;
  wire rd_load = word_done & ((in_cmd & ~cmd_wr) | (st_q == wshp_pkg::ST_RD));
  wire wr_word = word_done & (st_q == wshp_pkg::ST_WR);
  wire rd_step = word_done & (st_q == wshp_pkg::ST_RD);
  wire [3:0] rd_maddr = rd_step ? maddr_q + wshp_pkg::MADDR_ONE : maddr_q; // Next burst word

  // Register read selection
  wire [31:0] ctrl_val = {29'h0000_0000, run, attn_q, wake_q};
  wire [31:0] rd_val =
    (acc_addr == wshp_pkg::REG_CFG) ? {27'h000_0000, cfg_q} :
    (acc_addr == wshp_pkg::REG_MADDR) ? {28'h000_0000, maddr_q} :
    (acc_addr == wshp_pkg::REG_MDATA) ? mem_q[rd_maddr] :
    (acc_addr == wshp_pkg::REG_CTRL) ? ctrl_val : 32'h0000_0000;

  // Outgoing word in wire order, top-aligned
  // 16- and 32-bit orders
  wire [15:0] tx_w16 = wshp_pkg::order16(rd_val[15:0], ord);
  wire [31:0] tx_word = half ? {tx_w16, 16'h0000} : wshp_pkg::order32(rd_val, ord);
  wire mem_step = (rd_step | wr_word) & (addr_q == wshp_pkg::REG_MDATA);

  // Write decode
  wire wr_cfg = wr_word & (addr_q == wshp_pkg::REG_CFG);
  wire wr_maddr = wr_word & (addr_q == wshp_pkg::REG_MADDR);
  wire wr_ctrl = wr_word & (addr_q == wshp_pkg::REG_CTRL);
  wire attn_clr = wr_ctrl & rx_word[wshp_pkg::CTRL_ATTN];

  // Start-up: slow clock presence and strap capture
  // strap capture
  always_ff @(posedge SYS_CLK_I) begin
    if (!RST_N_I) begin
      slow_prev_q <= 1'b0;
      slow_cnt_q <= 2'h0;
      cap_cnt_q <= 2'h0;
      cap_done_q <= 1'b0;
      strap_q <= 1'b0;
    end else if (CE_I) begin
      slow_prev_q <= slow_s;
      if (slow_s && !slow_prev_q && !slow_ok && cap_done_q) begin // Skip sync settling edge
        slow_cnt_q <= slow_cnt_q + wshp_pkg::CNT2_ONE;
      end
      if (cap_cnt_q != wshp_pkg::CAP_DLY) begin
        cap_cnt_q <= cap_cnt_q + wshp_pkg::CNT2_ONE;
      end else if (!cap_done_q) begin
        strap_q <= strap_s;
        cap_done_q <= 1'b1;
      end
    end
  end

  // Frame tracking and bit alignment
  // frames are select-low only
  always_ff @(posedge SYS_CLK_I) begin
    if (!RST_N_I) begin
      sck_prev_q <= 1'b1;
      sel_n_prev_q <= 1'b1;
      bit_cnt_q <= wshp_pkg::BCNT_ZERO;
      st_q <= wshp_pkg::ST_CMD;
      addr_q <= wshp_pkg::REG_CFG;
    end else if (CE_I) begin
      sck_prev_q <= sck_s;
      sel_n_prev_q <= sel_n_s;
      if (!sel_act) begin
        bit_cnt_q <= wshp_pkg::BCNT_ZERO;
        st_q <= wshp_pkg::ST_CMD;
      end else if (word_done) begin
        bit_cnt_q <= wshp_pkg::BCNT_ZERO;
        if (in_cmd) begin
          st_q <= cmd_wr ? wshp_pkg::ST_WR : wshp_pkg::ST_RD;
          addr_q <= cmd_addr;
        end
      end else if (rise) begin
        bit_cnt_q <= bit_cnt_q + wshp_pkg::BCNT_ONE;
      end
    end
  end

  // Shift registers
  // sample on rise, launch on configured edge
  always_ff @(posedge SYS_CLK_I) begin
    if (!RST_N_I) begin
      rx_sr_q <= 32'h0000_0000;
      tx_sr_q <= 32'h0000_0000;
      out_q <= 1'b0;
    end else if (CE_I) begin
      if (rise) begin
        rx_sr_q <= rx_full;
      end
      if (rd_load && launch) begin
        out_q <= tx_word[31];
        tx_sr_q <= {tx_word[30:0], 1'b0};
      end else if (rd_load) begin
        tx_sr_q <= tx_word;
      end else if (launch && st_q == wshp_pkg::ST_RD) begin
        out_q <= tx_sr_q[31];
        tx_sr_q <= {tx_sr_q[30:0], 1'b0};
      end else if (launch || !sel_act) begin // Idle preset serves rise launch
        out_q <= cfg_q[wshp_pkg::CFG_FC] & run;
      end
    end
  end

  // Configuration, memory address, wake and attention
  // new configuration takes effect at frame end
  always_ff @(posedge SYS_CLK_I) begin
    if (!RST_N_I) begin
      cfg_q <= wshp_pkg::CFG_RST;
      cfg_pend_q <= wshp_pkg::CFG_RST;
      maddr_q <= 4'h0;
      wake_q <= 1'b0;
      attn_q <= 1'b0;
    end else if (CE_I) begin
      if (wr_cfg) begin
        cfg_pend_q <= rx_word[wshp_pkg::CFG_W-1:0];
      end
      if (frame_end) begin
        cfg_q <= cfg_pend_q;
      end
      if (wr_maddr) begin
        maddr_q <= rx_word[wshp_pkg::MEM_AW-1:0];
      end else if (mem_step) begin
        maddr_q <= maddr_q + wshp_pkg::MADDR_ONE;
      end
      if (wr_ctrl) begin
        wake_q <= rx_word[wshp_pkg::CTRL_WAKE];
      end
      attn_q <= ATTN_SET_I | (attn_q & ~attn_clr);
    end
  end

  // Internal memory write port
  // indirect write through fixed register
  always_ff @(posedge SYS_CLK_I) begin
    if (CE_I && wr_word && addr_q == wshp_pkg::REG_MDATA) begin
      mem_q[maddr_q] <= rx_word;
    end
  end

  // Outputs
  // undriven unless selected
  assign DEVICE_TO_HOST_LINE_O = out_q;
  assign DEVICE_TO_HOST_LINE_OE_N_O = ~sel_act;
  assign ATTENTION_REQUEST_OUT_O = attn_q;
  assign WAKE_O = wake_q;
  assign SPI_SELECTED_O = spi_mode;
  assign RUNNING_O = run;

  // Checks
  property p_oe_off;
    @(posedge SYS_CLK_I) disable iff (!RST_N_I)
    (sel_n_s || !pwr_s) |-> DEVICE_TO_HOST_LINE_OE_N_O;
  endproperty
  a_oe_off: assert property (p_oe_off) else $error("data line driven while idle");

  property p_idle_clock;
    @(posedge SYS_CLK_I) disable iff (!RST_N_I)
    (CE_I && $past(sel_n_s) && sel_n_s) |=> (bit_cnt_q == wshp_pkg::BCNT_ZERO) [*2];
  endproperty
  a_idle_clock: assert property (p_idle_clock) else $error("idle clock counted");

  property p_partial_drop;
    @(posedge SYS_CLK_I) disable iff (!RST_N_I)
    (CE_I && frame_end) |=> (bit_cnt_q == wshp_pkg::BCNT_ZERO && st_q == wshp_pkg::ST_CMD);
  endproperty
  a_partial_drop: assert property (p_partial_drop) else $error("partial word kept");

  property p_sample_rise;
    @(posedge SYS_CLK_I) disable iff (!RST_N_I)
    (CE_I && rise) |=> (rx_sr_q[0] == $past(mosi_s));
  endproperty
  a_sample_rise: assert property (p_sample_rise) else $error("bit not sampled");

  property p_fall_launch;
    @(posedge SYS_CLK_I) disable iff (!RST_N_I)
    (CE_I && fall && !sh_rise && st_q == wshp_pkg::ST_RD) |=> (out_q == $past(tx_sr_q[31]));
  endproperty
  a_fall_launch: assert property (p_fall_launch) else $error("wrong launch bit");

  property p_attn_set;
    @(posedge SYS_CLK_I) disable iff (!RST_N_I)
    (CE_I && ATTN_SET_I) |=> ATTENTION_REQUEST_OUT_O;
  endproperty
  a_attn_set: assert property (p_attn_set) else $error("attention lost");

  property p_cfg_frame;
    @(posedge SYS_CLK_I) disable iff (!RST_N_I)
    !frame_end |=> $stable(cfg_q);
  endproperty
  a_cfg_frame: assert property (p_cfg_frame) else $error("config changed mid-frame");

  property p_auto_inc;
    @(posedge SYS_CLK_I) disable iff (!RST_N_I)
    (CE_I && wr_word && addr_q == wshp_pkg::REG_MDATA)
      |=> (maddr_q == $past(maddr_q) + wshp_pkg::MADDR_ONE);
  endproperty
  a_auto_inc: assert property (p_auto_inc) else $error("address not advanced");

  property p_strap_hold;
    @(posedge SYS_CLK_I) disable iff (!RST_N_I)
    cap_done_q |=> ($stable(strap_q) && cap_done_q);
  endproperty
  a_strap_hold: assert property (p_strap_hold) else $error("strap recaptured");

  c_read_word: cover property (@(posedge SYS_CLK_I) disable iff (!RST_N_I)
    rd_load && st_q == wshp_pkg::ST_RD);
  c_write_mem: cover property (@(posedge SYS_CLK_I) disable iff (!RST_N_I)
    wr_word && addr_q == wshp_pkg::REG_MDATA);
  c_cfg_commit: cover property (@(posedge SYS_CLK_I) disable iff (!RST_N_I)
    frame_end && cfg_pend_q != cfg_q);
  c_attn_clear: cover property (@(posedge SYS_CLK_I) disable iff (!RST_N_I)
    attn_q && attn_clr);
endmodule : wshp_top

// File: wshp_host_model.sv
`timescale 1ns/10ps
module wshp_host_model (
  output logic sck_o,
  output logic mosi_o,
  output logic sel_n_o,
  input wire logic miso_i
);
  initial begin
    sck_o = 1'h1;
    mosi_o = 1'h0;
    sel_n_o = 1'h1;
  end

  task automatic sel(input logic v);
    sel_n_o = v;
    #100;
  endtask : sel

  task automatic shift(input logic [31:0] tx, input int n, output logic [31:0] rx);
    rx = 32'h0000_0000;
    for (int i = n - 1; i >= 0; i--) begin
      sck_o = 1'h0;
      mosi_o = tx[i];
      #88;
      sck_o = 1'h1;
      rx[i] = miso_i;
      #72;
    end
  endtask : shift
endmodule : wshp_host_model

// File: tb_top.sv
`timescale 1ns/10ps
module tb_top;
  logic clk, rst_n, strap, pwr, slow, attn_set, drove, cur_half, ce;
  logic sck, mosi, sel_n, d2h, oe_n, attn, wake, selected, running;
  logic [1:0] cur_ord;
  logic [31:0] dbuf[3];
  logic [31:0] rbuf[3];
  int fail_count = 0;
  int compares = 0;
  wire miso;

  // Host sees the line only while driven
  assign miso = oe_n ? 1'bz : d2h;

  wshp_top uut (
    .SYS_CLK_I(clk), .RST_N_I(rst_n), .CE_I(ce), .SPI_CLK_I(sck), .SPI_MOSI_I(mosi),
    .DEVICE_SELECT_N_I(sel_n), .INTERFACE_SELECT_STRAP_I(strap),
    .POWER_ENABLE_IN_I(pwr), .SLOW_CLOCK_IN_I(slow), .ATTN_SET_I(attn_set),
    .DEVICE_TO_HOST_LINE_O(d2h), .DEVICE_TO_HOST_LINE_OE_N_O(oe_n),
    .ATTENTION_REQUEST_OUT_O(attn), .WAKE_O(wake), .SPI_SELECTED_O(selected),
    .RUNNING_O(running)
  );

  wshp_host_model hst (.sck_o(sck), .mosi_o(mosi), .sel_n_o(sel_n), .miso_i(miso));

  // System clock and slow clock
  initial begin
    clk = 1'h0;
    forever #10 clk = ~clk;
  end
  initial begin
    slow = 1'h0;
    forever #15259 slow = ~slow;
  end

  // Notes any cycle with the line driven
  always @(posedge clk) begin
    if (oe_n === 1'h0) begin
      drove = 1'h1;
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      fail_count++;
      $display("FAIL t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic test_done();
    $display("compares=%0d fail_count=%0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : test_done

  // Logical word to wire order; each mapping undoes itself
  function automatic logic [31:0] wmap(input logic [31:0] w);
    if (cur_half) return {16'h0000, (cur_ord == 2'h1) ? {w[7:0], w[15:8]} : w[15:0]};
    if (cur_ord == 2'h0) return {w[15:0], w[31:16]};
    if (cur_ord == 2'h2) return {w[7:0], w[15:8], w[23:16], w[31:24]};
    return w;
  endfunction : wmap

  task automatic wait_run();
    for (int i = 0; i < 6000 && running !== 1'h1; i++) begin
      @(negedge clk);
    end
  endtask : wait_run

  // One frame: command word then n data words
  task automatic xfer(input logic wr, input logic [3:0] a, input int n);
    logic [31:0] rx;
    logic [31:0] ones;
    int nb;
    nb = cur_half ? 16 : 32;
    ones = cur_half ? 32'h0000_FFFF : 32'hFFFF_FFFF;
    @(negedge clk);
    #3;
    hst.sel(1'h0);
    hst.shift(wmap(cur_half ? {16'h0000, wr, 11'h000, a} : {wr, 27'h000_0000, a}), nb, rx);
    check(rx, ones);
    for (int i = 0; i < n; i++) begin
      hst.shift(wr ? wmap(dbuf[i]) : 32'h0000_0000, nb, rx);
      if (wr) begin
        check(rx, ones);
      end else begin
        rbuf[i] = wmap(rx);
      end
    end
    hst.sel(1'h1);
  endtask : xfer

  task automatic wr1(input logic [3:0] a, input logic [31:0] d);
    dbuf[0] = d;
    xfer(1'h1, a, 1);
  endtask : wr1

  task automatic rd1(input logic [3:0] a);
    xfer(1'h0, a, 1);
  endtask : rd1

  // Clocks a would-be write and expects the line never driven
  task automatic dead_frame(input logic s);
    logic [31:0] rx;
    @(negedge clk);
    #3;
    drove = 1'h0;
    hst.sel(s);
    hst.shift(32'h8000_0003, 32, rx);
    hst.sel(1'h1);
    check({31'h0000_0000, drove}, 32'h0000_0000);
  endtask : dead_frame

  initial begin
    #1500000;
    fail_count++;
    test_done();
  end

  initial begin
    logic [31:0] rx;
    rst_n = 1'h0;
    strap = 1'h0;
    pwr = 1'h1;
    attn_set = 1'h0;
    drove = 1'h0;
    ce = 1'h1;
    cur_half = 1'h0;
    cur_ord = 2'h1;
    repeat (10) @(negedge clk);
    check({26'h000_0000, oe_n, d2h, attn, wake, selected, running}, 32'h0000_0020);
    rst_n = 1'h1;
    wait_run();
    check({30'h0000_0000, selected, running}, 32'h0000_0003);
    dead_frame(1'h1);
    @(negedge clk);
    #3;
    hst.sel(1'h0);
    hst.shift(32'hFFFF_FFFF, 12, rx);
    hst.sel(1'h1);
    rd1(wshp_pkg::REG_CFG);
    check(rbuf[0], {27'h000_0000, wshp_pkg::CFG_RST});
    wr1(wshp_pkg::REG_MADDR, 32'h0000_0000);
    dbuf[0] = 32'h1357_9BDF;
    dbuf[1] = 32'h2468_ACE0;
    xfer(1'h1, wshp_pkg::REG_MDATA, 2);
    wr1(wshp_pkg::REG_MADDR, 32'h0000_0000);
    xfer(1'h0, wshp_pkg::REG_MDATA, 2);
    check(rbuf[0], 32'h1357_9BDF);
    check(rbuf[1], 32'h2468_ACE0);
    rd1(wshp_pkg::REG_MADDR);
    check(rbuf[0], 32'h0000_0002);
    for (int o = 0; o < 3; o++) begin
      wr1(wshp_pkg::REG_CFG, 32'h0000_0010 | o);
      cur_ord = o[1:0];
      wr1(wshp_pkg::REG_MADDR, 32'h0000_0001);
      rd1(wshp_pkg::REG_MDATA);
      check(rbuf[0], 32'h2468_ACE0);
      wr1(wshp_pkg::REG_MADDR, 32'h0000_0002 + o);
      wr1(wshp_pkg::REG_MDATA, 32'hC3A5_0F00 + o);
    end
    wr1(wshp_pkg::REG_CFG, 32'h0000_0011);
    cur_ord = 2'h1;
    wr1(wshp_pkg::REG_MADDR, 32'h0000_0002);
    xfer(1'h0, wshp_pkg::REG_MDATA, 3);
    for (int o = 0; o < 3; o++) begin
      check(rbuf[o], 32'hC3A5_0F00 + o);
    end
    for (int o = 0; o < 2; o++) begin
      wr1(wshp_pkg::REG_CFG, 32'h0000_0014 | o);
      cur_half = 1'h1;
      cur_ord = o[1:0];
      wr1(wshp_pkg::REG_MADDR, 32'h0000_0000);
      wr1(wshp_pkg::REG_MDATA, 32'h0000_BEE0 + o);
      wr1(wshp_pkg::REG_MADDR, 32'h0000_0000);
      rd1(wshp_pkg::REG_MDATA);
      check(rbuf[0], 32'h0000_BEE0 + o);
      wr1(wshp_pkg::REG_CFG, 32'h0000_0011);
      cur_half = 1'h0;
      cur_ord = 2'h1;
      wr1(wshp_pkg::REG_MADDR, 32'h0000_0000);
      rd1(wshp_pkg::REG_MDATA);
      check(rbuf[0], 32'h0000_BEE0 + o);
    end
    wr1(wshp_pkg::REG_CFG, 32'h0000_0019);
    wr1(wshp_pkg::REG_MADDR, 32'h0000_0001);
    rd1(wshp_pkg::REG_MDATA);
    check(rbuf[0], 32'h2468_ACE0);
    wr1(wshp_pkg::REG_CFG, 32'h0000_0011);
    @(negedge clk);
    attn_set = 1'h1;
    @(negedge clk);
    attn_set = 1'h0;
    repeat (4) @(negedge clk);
    check({31'h0000_0000, attn}, 32'h0000_0001);
    rd1(wshp_pkg::REG_CTRL);
    check(rbuf[0], 32'h0000_0006);
    wr1(wshp_pkg::REG_CTRL, 32'h0000_0003);
    rd1(wshp_pkg::REG_CTRL);
    check(rbuf[0], 32'h0000_0005);
    check({30'h0000_0000, wake, attn}, 32'h0000_0002);
    // Clock enable low freezes state, request lost
    @(negedge clk);
    ce = 1'h0;
    attn_set = 1'h1;
    repeat (3) @(negedge clk);
    attn_set = 1'h0;
    ce = 1'h1;
    @(negedge clk);
    check({30'h0000_0000, wake, attn}, 32'h0000_0002);
    wr1(4'h9, 32'hFFFF_FFFF);
    rd1(4'h9);
    check(rbuf[0], 32'h0000_0000);
    // power enable low stops the port
    @(negedge clk);
    pwr = 1'h0;
    repeat (5) @(negedge clk);
    check({31'h0000_0000, running}, 32'h0000_0000);
    dead_frame(1'h0);
    @(negedge clk);
    pwr = 1'h1;
    wait_run();
    // strap high picks the other port
    @(negedge clk);
    rst_n = 1'h0;
    strap = 1'h1;
    repeat (10) @(negedge clk);
    rst_n = 1'h1;
    wait_run();
    check({30'h0000_0000, selected, running}, 32'h0000_0001);
    dead_frame(1'h0);
    test_done();
  end
endmodule : tb_top
